// ===== shared/lpt_pkg.sv
// Constants shared by the panel timing block
// Functional notes
// - Pixel bus width selectable as one, two or four bits per shift clock.
// - Inversion setting complements every active pixel data bit.
// - Pixel at row zero, column zero goes out on bus bit zero.
// - Frame marker rises after first line pulse, falls at the next one.
// - Frame marker active level selectable high or low.
// - Line pulse follows each shifted line and lasts exactly 8 pixel clock periods.
// - Line pulse active level selectable high or low.
// - Shift clock paces the data; a setting inverts its polarity.
// - Polarity alternation output toggles every 1 to 16 frames, configurable.
package lpt_pkg;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 4;
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_GEOM = 4'h4;
	localparam logic [3:0] OFS_TIMING = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	// ==========================================================
	// Control fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_WID = 1;
	localparam int CTRL_WID_W = 2;
	localparam int CTRL_INV = 3;
	localparam int CTRL_MARK_LOW = 4;
	localparam int CTRL_LATCH_LOW = 5;
	localparam int CTRL_SCLK_INV = 6;

	// ==========================================================
	// Geometry and timing fields
	localparam int GEOM_PX = 0;
	localparam int GEOM_PX_W = 12;
	localparam int GEOM_LN = 16;
	localparam int GEOM_LN_W = 10;
	localparam int TIM_DIV = 0;
	localparam int TIM_DIV_W = 8;
	localparam int TIM_ALT = 8;
	localparam int TIM_ALT_W = 4;

	// ==========================================================
	// Status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_UNDERRUN = 1;
	localparam int STAT_POL = 2;
	localparam int STAT_MARK = 3;
	localparam int STAT_LINE = 16;

	// ==========================================================
	// Width codes
	localparam logic [1:0] WID_1 = 2'h0;
	localparam logic [1:0] WID_2 = 2'h1;
	localparam logic [1:0] WID_4 = 2'h2;

	// ==========================================================
	// Reset values and timing counts
	localparam logic [11:0] PX_RST = 12'h140;
	localparam logic [9:0] LN_RST = 10'h0f0;
	localparam logic [7:0] DIV_RST = 8'h03;
	localparam logic [3:0] ALT_RST = 4'h0;
	localparam logic [3:0] LATCH_PERIODS = 4'h8;

endpackage

// ===== core/lpt_pair_buffer.sv
// Small valid/ready buffer holding pixel words
`timescale 1ns/1ns
module lpt_pair_buffer #(
	parameter int W = 16,
	parameter int DEPTH = 2
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] ent;
		logic [CW-1:0] cnt;
		logic room;
	} lpt_buf_t;

	lpt_buf_t s_r;
	lpt_buf_t s_nxt;

	// ==========================================================
	// Next state
	always_comb begin
		logic pop;
		logic push;
		logic [CW-1:0] idx;
		pop = 1'b0;
		push = 1'b0;
		idx = '0;
		s_nxt = s_r;
		pop = out_ready && (s_r.cnt != '0);
		push = in_valid && s_r.room;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				s_nxt.ent[i] = s_r.ent[i+1];
			end
		end
		idx = s_r.cnt - CW'(pop);
		if (push) begin
			s_nxt.ent[idx] = in_data;
		end
		s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
		s_nxt.room = (s_nxt.cnt < CW'(DEPTH));
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= '{ent: '0, cnt: '0, room: 1'b1};
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	assign in_ready = s_r.room;
	assign out_valid = (s_r.cnt != '0);
	assign out_data = s_r.ent[0];
endmodule

// ===== core/lpt_panel_timing.sv
// Monochrome panel signal timing generator
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
module lpt_panel_timing #(
	parameter int WORD_W = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [lpt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic pix_valid,
	input wire logic [WORD_W-1:0] pix_data,
	output logic pix_ready,
	output logic [3:0] panel_pixel_bus,
	output logic pixel_shift_clock,
	output logic line_latch_pulse,
	output logic frame_start_marker,
	output logic crystal_polarity_toggle
);
	localparam int BW = $clog2(WORD_W + 1);

	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_LATCH} lpt_state_t;

	typedef struct packed {
		logic ctrl_en;
		logic [1:0] wid;
		logic inv;
		logic mark_low;
		logic latch_low;
		logic sclk_inv;
		logic [11:0] px_per_line;
		logic [9:0] lines;
		logic [7:0] div;
		logic [3:0] alt_per;
		lpt_state_t st;
		logic [7:0] div_cnt;
		logic phase;
		logic running;
		logic [WORD_W-1:0] word;
		logic [BW-1:0] word_bits;
		logic [11:0] px_left;
		logic [9:0] line;
		logic [3:0] lp_cnt;
		logic mark;
		logic pol;
		logic [3:0] alt_cnt;
		logic underrun;
		logic [3:0] pix;
		logic [3:0] bus;
		logic sclk;
		logic lp_o;
		logic flm_o;
		logic [31:0] rdata;
	} lpt_top_t;

	localparam lpt_top_t ST_RST = '{
		px_per_line: lpt_pkg::PX_RST,
		lines: lpt_pkg::LN_RST,
		div: lpt_pkg::DIV_RST,
		alt_per: lpt_pkg::ALT_RST,
		st: ST_IDLE,
		default: '0
	};

	lpt_top_t s_r;
	lpt_top_t s_nxt;

	logic buf_valid;
	logic [WORD_W-1:0] buf_data;
	logic buf_take;

	// ==========================================================
	// Helpers
	function automatic logic [2:0] width_bits(input logic [1:0] wid);
		case (wid)
			lpt_pkg::WID_2: width_bits = 3'h2;
			lpt_pkg::WID_4: width_bits = 3'h4;
			default: width_bits = 3'h1;
		endcase
	endfunction

	function automatic logic [3:0] width_mask(input logic [1:0] wid);
		case (wid)
			lpt_pkg::WID_2: width_mask = 4'h3;
			lpt_pkg::WID_4: width_mask = 4'hf;
			default: width_mask = 4'h1;
		endcase
	endfunction

	// ==========================================================
	// Word buffer
	lpt_pair_buffer #(
		.W(WORD_W),
		.DEPTH(2)
	) u_buf (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.in_valid(pix_valid),
		.in_data(pix_data),
		.in_ready(pix_ready),
		.out_valid(buf_valid),
		.out_data(buf_data),
		.out_ready(buf_take)
	);

	// ==========================================================
	// Next state
	always_comb begin
		logic start;
		logic [2:0] w;
		logic [WORD_W-1:0] src;
		start = 1'b0;
		w = 3'h1;
		src = '0;
		s_nxt = s_r;
		buf_take = 1'b0;

		// Register writes
		if (reg_wr) begin
			case (reg_addr)
				lpt_pkg::OFS_CTRL: begin
					s_nxt.ctrl_en = reg_wdata[lpt_pkg::CTRL_EN];
					s_nxt.wid = reg_wdata[lpt_pkg::CTRL_WID +: lpt_pkg::CTRL_WID_W];
					s_nxt.inv = reg_wdata[lpt_pkg::CTRL_INV];
					s_nxt.mark_low = reg_wdata[lpt_pkg::CTRL_MARK_LOW];
					s_nxt.latch_low = reg_wdata[lpt_pkg::CTRL_LATCH_LOW];
					s_nxt.sclk_inv = reg_wdata[lpt_pkg::CTRL_SCLK_INV];
				end
				lpt_pkg::OFS_GEOM: begin
					s_nxt.px_per_line = reg_wdata[lpt_pkg::GEOM_PX +: lpt_pkg::GEOM_PX_W];
					s_nxt.lines = reg_wdata[lpt_pkg::GEOM_LN +: lpt_pkg::GEOM_LN_W];
				end
				lpt_pkg::OFS_TIMING: begin
					s_nxt.div = reg_wdata[lpt_pkg::TIM_DIV +: lpt_pkg::TIM_DIV_W];
					s_nxt.alt_per = reg_wdata[lpt_pkg::TIM_ALT +: lpt_pkg::TIM_ALT_W];
				end
				lpt_pkg::OFS_STATUS: begin
					if (reg_wdata[lpt_pkg::STAT_UNDERRUN]) begin
						s_nxt.underrun = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads, data valid in the next cycle only
		s_nxt.rdata = '0;
		if (reg_rd) begin
			case (reg_addr)
				lpt_pkg::OFS_CTRL: begin
					s_nxt.rdata = {25'h0, s_r.sclk_inv, s_r.latch_low, s_r.mark_low, s_r.inv,
						s_r.wid, s_r.ctrl_en};
				end
				lpt_pkg::OFS_GEOM: begin
					s_nxt.rdata = {6'h0, s_r.lines, 4'h0, s_r.px_per_line};
				end
				lpt_pkg::OFS_TIMING: begin
					s_nxt.rdata = {20'h0, s_r.alt_per, s_r.div};
				end
				lpt_pkg::OFS_STATUS: begin
					s_nxt.rdata = {6'h0, s_r.line, 12'h0, s_r.mark, s_r.pol, s_r.underrun,
						(s_r.st != ST_IDLE)};
				end
				default: begin
					s_nxt.rdata = '0;
				end
			endcase
		end

		// Pixel clock divider
		if (s_r.st == ST_IDLE) begin
			s_nxt.div_cnt = s_r.div;
			s_nxt.phase = 1'b0;
		end else if (s_r.div_cnt == 8'h00) begin
			s_nxt.div_cnt = s_r.div;
			s_nxt.phase = ~s_r.phase;
			start = s_r.phase;
		end else begin
			s_nxt.div_cnt = s_r.div_cnt - 8'h01;
		end

		// Sequencer
		w = width_bits(s_r.wid);
		case (s_r.st)
			ST_IDLE: begin
				s_nxt.running = 1'b0;
				s_nxt.mark = 1'b0;
				s_nxt.pix = 4'h0;
				if (s_r.ctrl_en) begin
					s_nxt.st = ST_SHIFT;
					s_nxt.line = '0;
					s_nxt.px_left = s_r.px_per_line;
					s_nxt.word_bits = '0;
					s_nxt.alt_cnt = '0;
				end
			end
			ST_SHIFT: begin
				if (start) begin
					if (s_r.px_left == 12'h000) begin
						s_nxt.st = ST_LATCH;
						s_nxt.lp_cnt = lpt_pkg::LATCH_PERIODS - 4'h1;
						s_nxt.running = 1'b0;
						s_nxt.mark = 1'b0;
					end else if (s_r.word_bits == '0 && !buf_valid) begin
						s_nxt.running = 1'b0;
						s_nxt.underrun = 1'b1;
					end else begin
						if (s_r.word_bits == '0) begin
							buf_take = 1'b1;
							src = buf_data;
							s_nxt.word_bits = BW'(WORD_W) - BW'(w);
						end else begin
							src = s_r.word;
							s_nxt.word_bits = s_r.word_bits - BW'(w);
						end
						s_nxt.pix = src[3:0] & width_mask(s_r.wid);
						s_nxt.word = src >> w;
						s_nxt.px_left = s_r.px_left - 12'(w);
						s_nxt.running = 1'b1;
					end
				end
			end
			ST_LATCH: begin
				if (start) begin
					if (s_r.lp_cnt == 4'h0) begin
						s_nxt.st = ST_SHIFT;
						s_nxt.px_left = s_r.px_per_line;
						if (s_r.line == 10'h000) begin
							s_nxt.mark = 1'b1;
							if (s_r.alt_cnt == s_r.alt_per) begin
								s_nxt.pol = ~s_r.pol;
								s_nxt.alt_cnt = '0;
							end else begin
								s_nxt.alt_cnt = s_r.alt_cnt + 4'h1;
							end
						end
						if (s_r.line == s_r.lines - 10'h001) begin
							s_nxt.line = '0;
						end else begin
							s_nxt.line = s_r.line + 10'h001;
						end
					end else begin
						s_nxt.lp_cnt = s_r.lp_cnt - 4'h1;
					end
				end
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase

		// Disable stops everything at once
		if (!s_r.ctrl_en) begin
			s_nxt.st = ST_IDLE;
			s_nxt.running = 1'b0;
			s_nxt.mark = 1'b0;
			s_nxt.pix = 4'h0;
		end

		// Pin levels
		s_nxt.bus = s_nxt.pix ^ ({4{s_nxt.inv}} & width_mask(s_nxt.wid));
		s_nxt.sclk = (s_nxt.running & ~s_nxt.phase) ^ s_nxt.sclk_inv;
		s_nxt.lp_o = (s_nxt.st == ST_LATCH) ^ s_nxt.latch_low;
		s_nxt.flm_o = s_nxt.mark ^ s_nxt.mark_low;
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_r <= ST_RST;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata = s_r.rdata;
	assign panel_pixel_bus = s_r.bus;
	assign pixel_shift_clock = s_r.sclk;
	assign line_latch_pulse = s_r.lp_o;
	assign frame_start_marker = s_r.flm_o;
	assign crystal_polarity_toggle = s_r.pol;
endmodule

// ===== testbench/lpt_assertions.sv
// Checker for the panel timing block
`timescale 1ns/1ns
module lpt_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic [lpt_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [3:0] panel_pixel_bus,
	input wire logic pixel_shift_clock,
	input wire logic line_latch_pulse,
	input wire logic frame_start_marker,
	input wire logic crystal_polarity_toggle
);
	// ==========================================
	// Snooped settings
	logic [6:0] ctl;
	logic [7:0] div;
	logic [3:0] q, msk;
	logic [11:0] n;
	logic act, mk, ok, cw;
	assign cw = clk_en && reg_wr && reg_addr == lpt_pkg::OFS_CTRL;
	assign act = line_latch_pulse ^ ctl[5];
	assign mk = frame_start_marker ^ ctl[4];
	assign ok = ctl[0] && q == 4'hf;
	assign msk = ctl[2:1] == 2'h2 ? 4'hf : (ctl[2:1] == 2'h1 ? 4'h3 : 4'h1);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ctl <= 7'h00;
			div <= lpt_pkg::DIV_RST;
			q <= 4'h0;
			n <= 12'h000;
		end else begin
			if (cw)
				ctl <= reg_wdata[6:0];
			if (clk_en && reg_wr && reg_addr == lpt_pkg::OFS_TIMING)
				div <= reg_wdata[7:0];
			q <= cw ? 4'h0 : (q == 4'hf ? q : q + 4'h1);
			n <= act ? n + {11'h0, clk_en} : 12'h000;
		end
	end
	// ==========================================
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	a_bus_masked: assert property (ok |-> (panel_pixel_bus & ~msk) == 4'h0)
		else $error("idle bus bits driven");
	a_latch_len: assert property (ok && $fell(act) |-> n == {div, 4'h0} + 12'h010)
		else $error("line pulse length wrong");
	a_mark_rise: assert property (ok && $rose(mk) |-> $fell(act))
		else $error("marker rose off pulse end");
	a_mark_fall: assert property (ok && $fell(mk) |-> $rose(act))
		else $error("marker fell off pulse start");
	a_mark_gap: assert property (ok && mk |-> !act)
		else $error("marker overlaps pulse");
	a_pol_frame: assert property (ok && $changed(crystal_polarity_toggle) |-> $rose(mk))
		else $error("polarity changed mid frame");
	a_sclk_rest: assert property (ok && act |-> pixel_shift_clock == ctl[6])
		else $error("shift clock runs in pulse");
	a_data_sync: assert property (ok && $changed(panel_pixel_bus) |-> $rose(pixel_shift_clock ^ ctl[6]))
		else $error("data moved off clock");
	c_frame: cover property (ok && $rose(mk));
	c_latch: cover property (ok && $fell(act));
	c_toggle: cover property (ok && $changed(crystal_polarity_toggle));
endmodule

bind lpt_panel_timing lpt_checker u_lpt_checker (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .panel_pixel_bus(panel_pixel_bus),
	.pixel_shift_clock(pixel_shift_clock), .line_latch_pulse(line_latch_pulse),
	.frame_start_marker(frame_start_marker), .crystal_polarity_toggle(crystal_polarity_toggle));

// ===== testbench/lpt_panel_model.sv
// Passive panel model counting shifts, lines and frames
`timescale 1ns/1ns
module lpt_panel_model (
	input wire logic [6:0] ctl,
	input wire logic [3:0] bus,
	input wire logic sclk,
	input wire logic lat,
	input wire logic mark,
	input wire logic pol,
	output int shifts,
	output int nlat,
	output int nfrm,
	output int npol,
	output logic [3:0] first
);
	// ==========================================
	// Panel side
	int cnt;
	logic sck, la, mk;
	assign sck = sclk ^ ctl[6];
	assign la = lat ^ ctl[5];
	assign mk = mark ^ ctl[4];
	always @(negedge sck) begin
		if (cnt == 0)
			first = bus;
		cnt++;
	end
	always @(posedge la) begin
		shifts = cnt;
		cnt = 0;
		nlat++;
	end
	always @(posedge mk)
		nfrm++;
	always @(pol)
		npol++;
endmodule

// ===== testbench/lpt_panel_timing_bench.sv
// Testbench for the panel timing block
`timescale 1ns/1ns
module lpt_panel_timing_bench;
	logic clk, sys_rst, reg_wr, reg_rd, pix_valid, pix_ready, feed, sclk, lat, mark, pol, ce;
	logic [lpt_pkg::ADDR_W-1:0] reg_addr;
	logic [3:0] bus, first;
	logic [31:0] reg_wdata, reg_rdata, rv;
	logic [15:0] pix_data;
	logic [6:0] cfg;
	int fail_count, compares, cyc, shifts, nlat, nfrm, npol;
	lpt_panel_timing u_lpt_panel_timing (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pix_valid(pix_valid),
		.pix_data(pix_data), .pix_ready(pix_ready), .panel_pixel_bus(bus), .pixel_shift_clock(sclk),
		.line_latch_pulse(lat), .frame_start_marker(mark), .crystal_polarity_toggle(pol));
	lpt_panel_model u_lpt_panel_model (.ctl(cfg), .bus(bus), .sclk(sclk), .lat(lat), .mark(mark), .pol(pol),
		.shifts(shifts), .nlat(nlat), .nfrm(nfrm), .npol(npol), .first(first));
	// ==========================================
	// Clock, feed and tasks
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		pix_valid <= feed;
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask
	task automatic finish_test();
		$display("Compares %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs();
		rd(lpt_pkg::OFS_GEOM, rv);
		chk(rv, {6'h0, lpt_pkg::LN_RST, 4'h0, lpt_pkg::PX_RST});
		wr(4'h2, 32'hffff_ffff);
		rd(4'h2, rv);
		chk(rv, 32'h0);
		wr(lpt_pkg::OFS_TIMING, 32'h0000_0101);
		rd(lpt_pkg::OFS_TIMING, rv);
		chk(rv, 32'h0000_0101);
	endtask
	task automatic t_buf();
		repeat (4) @(posedge clk);
		chk({31'h0, pix_ready}, 32'h0);
		feed <= 1'b0;
		wr(lpt_pkg::OFS_CTRL, 32'h5);
		repeat (300) @(posedge clk);
		rd(lpt_pkg::OFS_STATUS, rv);
		chk(rv & 32'h2, 32'h2);
		wr(lpt_pkg::OFS_CTRL, 32'h0);
		feed <= 1'b1;
	endtask
	task automatic t_line(input logic [6:0] c, input int w);
		int b;
		int i;
		logic [3:0] m;
		m = (w == 4) ? 4'hf : ((w == 2) ? 4'h3 : 4'h1);
		cfg = c;
		wr(lpt_pkg::OFS_CTRL, {25'h0, c});
		b = nlat;
		for (i = 0; i < 3000 && nlat < b + 4; i++)
			@(posedge clk);
		chk(32'(shifts), 32'(16 / w));
		chk({28'h0, first}, {28'h0, (4'hb ^ {4{c[3]}}) & m});
		wr(lpt_pkg::OFS_CTRL, 32'h0);
	endtask
	task automatic t_frame();
		int f;
		int p;
		int i;
		cfg = 7'h05;
		wr(lpt_pkg::OFS_TIMING, 32'h0000_0201);
		wr(lpt_pkg::OFS_CTRL, 32'h5);
		f = nfrm;
		p = npol;
		for (i = 0; i < 5000 && nfrm < f + 6; i++)
			@(posedge clk);
		@(posedge clk);
		chk(32'(npol - p), 32'h2);
	endtask
	task automatic t_hold();
		logic [7:0] held;
		int b;
		int i;
		ce <= 1'b0;
		@(posedge clk);
		held = {bus, sclk, lat, mark, pol};
		repeat (20) @(posedge clk);
		chk({24'h0, bus, sclk, lat, mark, pol}, {24'h0, held});
		ce <= 1'b1;
		b = nlat;
		for (i = 0; i < 1000 && nlat < b + 2; i++)
			@(posedge clk);
		chk(32'(shifts), 32'h4);
	endtask
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		feed = 1'b1;
		ce = 1'b1;
		pix_data = 16'h842b;
		cfg = 7'h00;
		repeat (8) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		t_regs();
		wr(lpt_pkg::OFS_GEOM, 32'h0002_0010);
		t_buf();
		t_line(7'h01, 1);
		t_line(7'h03, 2);
		t_line(7'h05, 4);
		t_line(7'h7d, 4);
		t_frame();
		t_hold();
		finish_test();
	end
endmodule
